// ===== design/octal_map_pkg.sv
// holds offsets, field positions, reset values and counter widths for the
// eight-port register map; assumes byte addresses are four times the index
`default_nettype none
package octal_map_pkg;
   // =========================================================================
   // address layout
   localparam int PORTS     = 8;
   localparam int ADR_W     = 10;     // byte address width on the bus
   localparam int IDX_LSB   = 2;      // byte address = 4 * register index
   localparam int OFS_MSB   = 6;      // section bit plus register index
   localparam int PORT_LSB  = 7;
   localparam int PORT_MSB  = 9;
   localparam int DW        = 8;
   // =========================================================================
   // register offsets within one port block, section bit included
   localparam logic [4:0] OFS_TX_COMMON   = 5'h00;
   localparam logic [4:0] OFS_TX_TRIG     = 5'h01;
   localparam logic [4:0] OFS_TX_CNT_HI   = 5'h02;
   localparam logic [4:0] OFS_TX_CNT_LO   = 5'h03;
   localparam logic [4:0] OFS_TX_IDLE     = 5'h04;
   localparam logic [4:0] OFS_TX_HEC_PAT  = 5'h05;
   localparam logic [4:0] OFS_TX_CTRL1    = 5'h06;
   localparam logic [4:0] OFS_TX_CTRL2    = 5'h07;
   localparam logic [4:0] OFS_IRQ_CAUSE   = 5'h08;
   localparam logic [4:0] OFS_RX_COMMON   = 5'h10;
   localparam logic [4:0] OFS_RX_LOSS     = 5'h11;
   localparam logic [4:0] OFS_RX_TRIG     = 5'h12;
   localparam logic [4:0] OFS_RX_CORR     = 5'h13;
   localparam logic [4:0] OFS_RX_UNC_HI   = 5'h14;
   localparam logic [4:0] OFS_RX_UNC_LO   = 5'h15;
   localparam logic [4:0] OFS_RX_CNT_HI   = 5'h16;
   localparam logic [4:0] OFS_RX_CNT_LO   = 5'h17;
   localparam logic [4:0] OFS_PSTATE      = 5'h18;
   localparam logic [4:0] OFS_RX_CTRL1    = 5'h19;
   localparam logic [4:0] OFS_RX_CTRL2    = 5'h1A;
   localparam logic [4:0] OFS_RX_FCTRL    = 5'h1B;
   localparam logic [4:0] OFS_RX_FW0      = 5'h1C;
   localparam logic [4:0] OFS_RX_FW1      = 5'h1D;
   localparam logic [4:0] OFS_RX_FW2      = 5'h1E;
   localparam logic [4:0] OFS_RX_FW3      = 5'h1F;
   // =========================================================================
   // reset values
   localparam logic [7:0] RST_TX_COMMON   = 8'h10;
   localparam logic [7:0] RST_TX_IDLE     = 8'h6A;
   localparam logic [7:0] RST_TX_HEC_PAT  = 8'h29;
   localparam logic [7:0] RST_TX_CTRL1    = 8'h05;
   localparam logic [7:0] RST_ZERO        = 8'h00;
   // =========================================================================
   // counters
   localparam int          CNT_W   = 16;
   localparam int          UNC_W   = 12;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [11:0] UNC_MAX = 12'hFFF;
   localparam logic [7:0]  COR_MAX = 8'hFF;
endpackage
`default_nettype wire

// ===== design/octal_port_register_map.sv
// register decoder and storage for an eight-port cell-mapping device
// assumes a classic wishbone master on CLOCK and event pulses from the
// cell datapath on the same clock, so no event input is synchronised
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module octal_port_register_map #(
   parameter int PORTS = 8
) (
   input  wire logic          CLOCK,
   input  wire logic          RESETN,
   input  wire logic          WB_CYC_I,
   input  wire logic          WB_STB_I,
   input  wire logic          WB_WE_I,
   input  wire logic [9:0]    WB_ADR_I,
   input  wire logic [3:0]    WB_SEL_I,
   input  wire logic [31:0]   WB_DAT_I,
   output logic      [31:0]   WB_DAT_O,
   output logic               WB_ACK_O,
   input  wire logic [7:0]    TX_CELL_DONE,
   input  wire logic [7:0]    RX_CELL_OK,
   input  wire logic [7:0]    RX_HEC_FIXED,
   input  wire logic [7:0]    RX_HEC_BAD,
   input  wire logic [63:0]   PORT_STATE,
   input  wire logic [7:0]    IRQ_CAUSE,
   output logic      [7:0]    TX_COMMON_CFG,
   output logic      [7:0]    TX_IDLE_BYTE,
   output logic      [7:0]    TX_HEC_PATTERN,
   output logic      [7:0]    RX_COMMON_CFG,
   output logic      [7:0]    RX_LOSS_PERIOD,
   output logic      [63:0]   TX_CTRL_ONE,
   output logic      [63:0]   TX_CTRL_TWO,
   output logic      [63:0]   RX_CTRL_ONE,
   output logic      [63:0]   RX_CTRL_TWO,
   output logic      [63:0]   RX_FILTER_CTRL,
   output logic      [255:0]  RX_FILTER_WORDS
);
   // =========================================================================
   // elaboration check
   // the three-bit port field cannot serve any other port count
   generate
      if (PORTS != octal_map_pkg::PORTS) begin : g_bad_ports
         $error("PORTS must be 8");
      end
   endgenerate

   // =========================================================================
   // state
   logic                         ack_ff;
   logic [31:0]                  dat_ff;
   logic [7:0]                   tx_common_ff;
   logic [7:0]                   tx_idle_ff;
   logic [7:0]                   tx_hec_pat_ff;
   logic [7:0]                   rx_common_ff;
   logic [7:0]                   rx_loss_ff;
   logic [7:0]                   tx_ctrl_one_ff  [PORTS];
   logic [7:0]                   tx_ctrl_two_ff  [PORTS];
   logic [7:0]                   rx_ctrl_one_ff  [PORTS];
   logic [7:0]                   rx_ctrl_two_ff  [PORTS];
   logic [7:0]                   rx_fctrl_ff     [PORTS];
   logic [7:0]                   rx_fword_ff     [PORTS][4];
   logic [15:0]                  tx_cnt_ff       [PORTS];
   logic [15:0]                  rx_cnt_ff       [PORTS];
   logic [7:0]                   cor_cnt_ff      [PORTS];
   logic [11:0]                  unc_cnt_ff      [PORTS];
   logic [15:0]                  tx_latch_ff;
   logic [15:0]                  rx_latch_ff;
   logic [2:0]                   tx_cap_port_ff;
   logic [2:0]                   rx_cap_port_ff;

   // =========================================================================
   // address decode
   logic [2:0]                   port;
   logic [4:0]                   ofs;
   logic                         first;
   logic                         req;
   logic                         wr;
   logic                         wr_tx_trig;
   logic                         wr_rx_trig;
   logic [7:0]                   wdat;
   logic [7:0]                   rdat;

   // port, section and index fields of the byte address
   assign port  = WB_ADR_I[octal_map_pkg::PORT_MSB:octal_map_pkg::PORT_LSB];
   assign ofs   = WB_ADR_I[octal_map_pkg::OFS_MSB:octal_map_pkg::IDX_LSB];
   assign first = (port == 3'h0);
   assign req   = WB_CYC_I & WB_STB_I;
   // a write lands on the edge at which the master sees ack high
   assign wr    = req & ack_ff & WB_WE_I & WB_SEL_I[0];
   assign wdat  = WB_DAT_I[7:0];
   // reserved bits are stored as written; software keeps them zero
   assign wr_tx_trig = wr & (ofs == octal_map_pkg::OFS_TX_TRIG);
   assign wr_rx_trig = wr & (ofs == octal_map_pkg::OFS_RX_TRIG);

   // =========================================================================
   // bus answer
   // one-cycle ack; the gap after it keeps back-to-back strobes apart
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // read data is sampled with the request, before ack rises
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         dat_ff <= 32'h0000_0000;
      end else if (req & ~ack_ff) begin
         dat_ff <= {24'h00_0000, rdat};
      end
   end

   // read mux; reserved, trigger and empty slots all read zero
   always_comb begin
      rdat = 8'h00;
      case (ofs)
         octal_map_pkg::OFS_TX_COMMON:  if (first) rdat = tx_common_ff;
         octal_map_pkg::OFS_TX_CNT_HI:  rdat = tx_latch_ff[15:8];
         octal_map_pkg::OFS_TX_CNT_LO:  rdat = tx_latch_ff[7:0];
         octal_map_pkg::OFS_TX_IDLE:    if (first) rdat = tx_idle_ff;
         octal_map_pkg::OFS_TX_HEC_PAT: if (first) rdat = tx_hec_pat_ff;
         octal_map_pkg::OFS_TX_CTRL1:   rdat = tx_ctrl_one_ff[port];
         octal_map_pkg::OFS_TX_CTRL2:   rdat = tx_ctrl_two_ff[port];
         octal_map_pkg::OFS_IRQ_CAUSE:  if (first) rdat = IRQ_CAUSE;
         octal_map_pkg::OFS_RX_COMMON:  if (first) rdat = rx_common_ff;
         octal_map_pkg::OFS_RX_LOSS:    if (first) rdat = rx_loss_ff;
         octal_map_pkg::OFS_RX_CORR:    rdat = cor_cnt_ff[port];
         octal_map_pkg::OFS_RX_UNC_HI:  rdat = {4'h0, unc_cnt_ff[port][11:8]};
         octal_map_pkg::OFS_RX_UNC_LO:  rdat = unc_cnt_ff[port][7:0];
         octal_map_pkg::OFS_RX_CNT_HI:  rdat = rx_latch_ff[15:8];
         octal_map_pkg::OFS_RX_CNT_LO:  rdat = rx_latch_ff[7:0];
         octal_map_pkg::OFS_PSTATE:     rdat = PORT_STATE[port*8 +: 8];
         octal_map_pkg::OFS_RX_CTRL1:   rdat = rx_ctrl_one_ff[port];
         octal_map_pkg::OFS_RX_CTRL2:   rdat = rx_ctrl_two_ff[port];
         octal_map_pkg::OFS_RX_FCTRL:   rdat = rx_fctrl_ff[port];
         octal_map_pkg::OFS_RX_FW0:     rdat = rx_fword_ff[port][0];
         octal_map_pkg::OFS_RX_FW1:     rdat = rx_fword_ff[port][1];
         octal_map_pkg::OFS_RX_FW2:     rdat = rx_fword_ff[port][2];
         octal_map_pkg::OFS_RX_FW3:     rdat = rx_fword_ff[port][3];
         default:                       rdat = 8'h00;
      endcase
   end

   // =========================================================================
   // common registers
   // only the first port's slot reaches these; other slots drop the write
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         tx_common_ff  <= octal_map_pkg::RST_TX_COMMON;
         tx_idle_ff    <= octal_map_pkg::RST_TX_IDLE;
         tx_hec_pat_ff <= octal_map_pkg::RST_TX_HEC_PAT;
         rx_common_ff  <= octal_map_pkg::RST_ZERO;
         rx_loss_ff    <= octal_map_pkg::RST_ZERO;
      end else if (wr & first) begin
         case (ofs)
            octal_map_pkg::OFS_TX_COMMON:  tx_common_ff  <= wdat;
            octal_map_pkg::OFS_TX_IDLE:    tx_idle_ff    <= wdat;
            octal_map_pkg::OFS_TX_HEC_PAT: tx_hec_pat_ff <= wdat;
            octal_map_pkg::OFS_RX_COMMON:  rx_common_ff  <= wdat;
            octal_map_pkg::OFS_RX_LOSS:    rx_loss_ff    <= wdat;
            default: ;
         endcase
      end
   end

   // =========================================================================
   // per-port control and filter registers
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < PORTS; i++) begin
            tx_ctrl_one_ff[i] <= octal_map_pkg::RST_TX_CTRL1;
            tx_ctrl_two_ff[i] <= octal_map_pkg::RST_ZERO;
            rx_ctrl_one_ff[i] <= octal_map_pkg::RST_ZERO;
            rx_ctrl_two_ff[i] <= octal_map_pkg::RST_ZERO;
            rx_fctrl_ff[i]    <= octal_map_pkg::RST_ZERO;
            for (int k = 0; k < 4; k++) begin
               rx_fword_ff[i][k] <= octal_map_pkg::RST_ZERO;
            end
         end
      end else if (wr) begin
         case (ofs)
            octal_map_pkg::OFS_TX_CTRL1: tx_ctrl_one_ff[port]  <= wdat;
            octal_map_pkg::OFS_TX_CTRL2: tx_ctrl_two_ff[port]  <= wdat;
            octal_map_pkg::OFS_RX_CTRL1: rx_ctrl_one_ff[port]  <= wdat;
            octal_map_pkg::OFS_RX_CTRL2: rx_ctrl_two_ff[port]  <= wdat;
            octal_map_pkg::OFS_RX_FCTRL: rx_fctrl_ff[port]     <= wdat;
            octal_map_pkg::OFS_RX_FW0:   rx_fword_ff[port][0]  <= wdat;
            octal_map_pkg::OFS_RX_FW1:   rx_fword_ff[port][1]  <= wdat;
            octal_map_pkg::OFS_RX_FW2:   rx_fword_ff[port][2]  <= wdat;
            octal_map_pkg::OFS_RX_FW3:   rx_fword_ff[port][3]  <= wdat;
            default: ;
         endcase
      end
   end

   // =========================================================================
   // per-port running counters
   // a cell arriving with the trigger restarts the count at one, not lost
   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_port
         logic tx_hit;
         logic rx_hit;
         assign tx_hit = wr_tx_trig & (port == 3'(g));
         assign rx_hit = wr_rx_trig & (port == 3'(g));

         always_ff @(posedge CLOCK or negedge RESETN) begin
            if (!RESETN) begin
               tx_cnt_ff[g] <= 16'h0000;
            end else if (tx_hit) begin
               tx_cnt_ff[g] <= {15'h0000, TX_CELL_DONE[g]};
            end else if (TX_CELL_DONE[g] && tx_cnt_ff[g] != octal_map_pkg::CNT_MAX) begin
               tx_cnt_ff[g] <= tx_cnt_ff[g] + 16'h0001;
            end
         end

         always_ff @(posedge CLOCK or negedge RESETN) begin
            if (!RESETN) begin
               rx_cnt_ff[g] <= 16'h0000;
            end else if (rx_hit) begin
               rx_cnt_ff[g] <= {15'h0000, RX_CELL_OK[g]};
            end else if (RX_CELL_OK[g] && rx_cnt_ff[g] != octal_map_pkg::CNT_MAX) begin
               rx_cnt_ff[g] <= rx_cnt_ff[g] + 16'h0001;
            end
         end

         // header error counts saturate and are never cleared by software
         always_ff @(posedge CLOCK or negedge RESETN) begin
            if (!RESETN) begin
               cor_cnt_ff[g] <= 8'h00;
               unc_cnt_ff[g] <= 12'h000;
            end else begin
               if (RX_HEC_FIXED[g] && cor_cnt_ff[g] != octal_map_pkg::COR_MAX) begin
                  cor_cnt_ff[g] <= cor_cnt_ff[g] + 8'h01;
               end
               if (RX_HEC_BAD[g] && unc_cnt_ff[g] != octal_map_pkg::UNC_MAX) begin
                  unc_cnt_ff[g] <= unc_cnt_ff[g] + 12'h001;
               end
            end
         end

         // flat copies of the per-port registers toward the datapath
         assign TX_CTRL_ONE[g*8 +: 8]    = tx_ctrl_one_ff[g];
         assign TX_CTRL_TWO[g*8 +: 8]    = tx_ctrl_two_ff[g];
         assign RX_CTRL_ONE[g*8 +: 8]    = rx_ctrl_one_ff[g];
         assign RX_CTRL_TWO[g*8 +: 8]    = rx_ctrl_two_ff[g];
         assign RX_FILTER_CTRL[g*8 +: 8] = rx_fctrl_ff[g];
         assign RX_FILTER_WORDS[g*32 +: 32] =
            {rx_fword_ff[g][3], rx_fword_ff[g][2], rx_fword_ff[g][1], rx_fword_ff[g][0]};
      end
   endgenerate

   // =========================================================================
   // shared count latches
   // both bytes load on one edge so the pair never mixes two samples
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         tx_latch_ff    <= 16'h0000;
         tx_cap_port_ff <= 3'h0;
      end else if (wr_tx_trig) begin
         tx_latch_ff    <= tx_cnt_ff[port];
         tx_cap_port_ff <= port;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         rx_latch_ff    <= 16'h0000;
         rx_cap_port_ff <= 3'h0;
      end else if (wr_rx_trig) begin
         rx_latch_ff    <= rx_cnt_ff[port];
         rx_cap_port_ff <= port;
      end
   end

   // =========================================================================
   // outputs
   assign WB_ACK_O       = ack_ff;
   assign WB_DAT_O       = dat_ff;
   assign TX_COMMON_CFG  = tx_common_ff;
   assign TX_IDLE_BYTE   = tx_idle_ff;
   assign TX_HEC_PATTERN = tx_hec_pat_ff;
   assign RX_COMMON_CFG  = rx_common_ff;
   assign RX_LOSS_PERIOD = rx_loss_ff;

   // =========================================================================
   // assertions
   logic [15:0] tx_cnt_sel;
   logic [15:0] rx_cnt_sel;
   assign tx_cnt_sel = tx_cnt_ff[port];
   assign rx_cnt_sel = rx_cnt_ff[port];

   // every access, refused or not, gets exactly one ack pulse
   AST_ACK_ANSWER: assert property (@(posedge CLOCK) disable iff (!RESETN)
      req && !ack_ff |=> ack_ff ##1 !ack_ff)
      else $error("ack did not pulse for one cycle");

   // a stray ack would commit a requested write in the first cycle of its request
   AST_ACK_IDLE: assert property (@(posedge CLOCK) disable iff (!RESETN)
      !req |=> !ack_ff)
      else $error("ack without a request");

   AST_TX_CAPTURE: assert property (@(posedge CLOCK) disable iff (!RESETN)
      wr_tx_trig |=> tx_latch_ff == $past(tx_cnt_sel))
      else $error("tx latch missed the triggered count");

   AST_RX_CAPTURE: assert property (@(posedge CLOCK) disable iff (!RESETN)
      wr_rx_trig |=> rx_latch_ff == $past(rx_cnt_sel))
      else $error("rx latch missed the triggered count");

   AST_TX_CLEAR: assert property (@(posedge CLOCK) disable iff (!RESETN)
      wr_tx_trig |=> tx_cnt_ff[tx_cap_port_ff] <= 16'h0001)
      else $error("tx count not cleared by capture");

   AST_RX_CLEAR: assert property (@(posedge CLOCK) disable iff (!RESETN)
      wr_rx_trig |=> rx_cnt_ff[rx_cap_port_ff] <= 16'h0001)
      else $error("rx count not cleared by capture");

   AST_LATCH_HOLD: assert property (@(posedge CLOCK) disable iff (!RESETN)
      !wr_tx_trig && !wr_rx_trig |=> $stable(tx_latch_ff) && $stable(rx_latch_ff))
      else $error("latch changed without a trigger");

   AST_COMMON_SLOT: assert property (@(posedge CLOCK) disable iff (!RESETN)
      wr && !first |=> $stable(tx_common_ff) && $stable(tx_idle_ff) &&
      $stable(tx_hec_pat_ff) && $stable(rx_common_ff) && $stable(rx_loss_ff))
      else $error("common register written from another port");

   AST_RESERVED_READ: assert property (@(posedge CLOCK) disable iff (!RESETN)
      req && !ack_ff && !WB_WE_I && !first &&
      (ofs == octal_map_pkg::OFS_TX_COMMON || ofs == octal_map_pkg::OFS_IRQ_CAUSE)
      |=> WB_DAT_O == 32'h0000_0000)
      else $error("reserved slot read nonzero");

   AST_TRIG_READ: assert property (@(posedge CLOCK) disable iff (!RESETN)
      req && !ack_ff && !WB_WE_I && (ofs == octal_map_pkg::OFS_TX_TRIG ||
      ofs == octal_map_pkg::OFS_RX_TRIG) |=> WB_DAT_O == 32'h0000_0000)
      else $error("write-only register read nonzero");

   AST_CTRL_WRITE: assert property (@(posedge CLOCK) disable iff (!RESETN)
      wr && ofs == octal_map_pkg::OFS_TX_CTRL1
      |=> TX_CTRL_ONE[$past(port)*8 +: 8] == $past(wdat))
      else $error("per-port control write lost");

   AST_LATCH_READ: assert property (@(posedge CLOCK) disable iff (!RESETN)
      req && !ack_ff && !WB_WE_I && ofs == octal_map_pkg::OFS_RX_CNT_HI
      |=> WB_DAT_O[7:0] == rx_latch_ff[15:8])
      else $error("shared latch read wrong byte");

   AST_TX_LATCH_READ: assert property (@(posedge CLOCK) disable iff (!RESETN)
      req && !ack_ff && !WB_WE_I && ofs == octal_map_pkg::OFS_TX_CNT_LO
      |=> WB_DAT_O[7:0] == tx_latch_ff[7:0])
      else $error("shared tx latch read wrong byte");
endmodule
`default_nettype wire

// ===== tb/test_octal_port_register_map.sv
// bench for the eight-port register map: wishbone tasks and directed checks
// assumes the design package is compiled first and one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %0h expected %0h", $time, (g), (e)); end end
module test_octal_port_register_map;
   // ======================================================================
   // stimulus and observation
   logic           clock = 1'b0;
   logic           resetn = 1'b0;
   logic           cyc = 1'b0;
   logic           stb = 1'b0;
   logic           we = 1'b0;
   logic [9:0]     adr = 10'h000;
   logic [3:0]     sel = 4'h0;
   logic [31:0]    dat = 32'h0;
   logic [31:0]    ev = 32'h0;    // tx done, rx ok, hec fixed, hec bad
   logic [63:0]    pstate = 64'h0000_009B_0000_0000;
   logic [7:0]     irq = 8'h5A;
   logic [31:0]    dat_o;
   logic           ack;
   logic [7:0]     tx_cfg;
   logic [63:0]    tx_c1;
   logic [7:0]     idle_o;
   logic [7:0]     hec_o;
   logic [7:0]     rxc_o;
   logic [7:0]     loss_o;
   logic [63:0]    tx_c2;
   logic [63:0]    rx_c1;
   logic [63:0]    rx_c2;
   logic [63:0]    fctl;
   logic [255:0]   fwords;
   logic [7:0]     q;
   int             errors = 0;
   int             num_checks = 0;
   int             cycles = 0;
   // ======================================================================
   // device
   octal_port_register_map dut_u (.CLOCK(clock), .RESETN(resetn), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TX_CELL_DONE(ev[7:0]), .RX_CELL_OK(ev[15:8]),
      .RX_HEC_FIXED(ev[23:16]), .RX_HEC_BAD(ev[31:24]), .PORT_STATE(pstate),
      .IRQ_CAUSE(irq), .TX_COMMON_CFG(tx_cfg), .TX_IDLE_BYTE(idle_o),
      .TX_HEC_PATTERN(hec_o), .RX_COMMON_CFG(rxc_o), .RX_LOSS_PERIOD(loss_o),
      .TX_CTRL_ONE(tx_c1), .TX_CTRL_TWO(tx_c2), .RX_CTRL_ONE(rx_c1),
      .RX_CTRL_TWO(rx_c2), .RX_FILTER_CTRL(fctl), .RX_FILTER_WORDS(fwords));
   // ======================================================================
   // clock and hang guard, sized well above the directed sequence
   always #4 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   // one classic cycle; held until ack is sampled, read data taken there
   task automatic xfer(input logic w, input logic [2:0] p, input logic [4:0] o,
                       input logic [7:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {p, o, 2'b00};
      dat <= {24'h0, d};
      sel <= 4'h1;
      do @(posedge clock); while (ack !== 1'b1);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // event pulse held high for n sampling edges
   task automatic pulse(input int b, input int n);
      @(posedge clock);
      ev[b] <= 1'b1;
      repeat (n) @(posedge clock);
      ev <= 32'h0;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ======================================================================
   // directed sequence
   initial begin
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      xfer(0, 0, 5'h00, 0); `CHK(q, octal_map_pkg::RST_TX_COMMON)
      xfer(0, 0, 5'h04, 0); `CHK(q, 8'h6A)
      xfer(0, 0, 5'h05, 0); `CHK(q, 8'h29)
      xfer(0, 6, 5'h06, 0); `CHK(q, 8'h05)
      @(negedge clock); `CHK(idle_o, octal_map_pkg::RST_TX_IDLE)
      `CHK(hec_o, octal_map_pkg::RST_TX_HEC_PAT)
      `CHK({rxc_o, loss_o}, 16'h0000)
      `CHK(tx_c2[63:56], 8'h00)
      done("reset");
      for (int p = 0; p < 8; p++) xfer(1, p[2:0], 5'h19, 8'(8'hA0 + p));
      xfer(1, 2, 5'h06, 8'h5C);
      for (int p = 0; p < 8; p++) begin
         xfer(0, p[2:0], 5'h19, 0); `CHK(q, 8'(8'hA0 + p))
      end
      @(negedge clock); `CHK(tx_c1[23:16], 8'h5C)
      `CHK(rx_c1[63:56], 8'hA7)
      xfer(1, 0, 5'h07, 8'h81);
      xfer(0, 0, 5'h07, 0); `CHK(q, 8'h81)
      for (int k = 0; k < 4; k++) xfer(1, 7, 5'(5'h1C + k), 8'(8'h11 * (k + 1)));
      @(negedge clock); `CHK(fwords[255:224], 32'h4433_2211)
      `CHK(tx_c2[7:0], 8'h81)
      done("per-port");
      xfer(1, 1, 5'h00, 8'h03);
      xfer(0, 1, 5'h00, 0); `CHK(q, 8'h00)
      xfer(0, 0, 5'h00, 0); `CHK(q, 8'h10)
      xfer(1, 0, 5'h00, 8'h03);
      @(negedge clock); `CHK(tx_cfg, 8'h03)
      xfer(0, 4, 5'h18, 0); `CHK(q, 8'h9B)
      xfer(0, 0, 5'h08, 0); `CHK(q, 8'h5A)
      xfer(0, 1, 5'h08, 0); `CHK(q, 8'h00)
      // remaining common and per-port registers, written only in defined slots
      xfer(1, 0, 5'h10, 8'h3C);
      xfer(1, 0, 5'h11, 8'hC4);
      xfer(1, 0, 5'h04, 8'h55);
      xfer(1, 0, 5'h05, 8'h12);
      xfer(1, 5, 5'h1A, 8'h7E);
      xfer(1, 5, 5'h1B, 8'h0F);
      @(negedge clock); `CHK({rxc_o, loss_o}, 16'h3CC4)
      `CHK({idle_o, hec_o}, 16'h5512)
      `CHK({rx_c2[47:40], fctl[47:40]}, 16'h7E0F)
      xfer(0, 0, 5'h11, 0); `CHK(q, 8'hC4)
      xfer(0, 5, 5'h1B, 0); `CHK(q, 8'h0F)
      xfer(0, 3, 5'h1A, 0); `CHK(q, 8'h00)
      done("common");
      pulse(3, 3);
      xfer(1, 3, 5'h01, 8'h00);
      xfer(1, 2, 5'h03, 8'hFF);
      xfer(0, 5, 5'h02, 0); `CHK(q, 8'h00)
      xfer(0, 5, 5'h03, 0); `CHK(q, 8'h03)
      pulse(3, 2);
      xfer(0, 0, 5'h03, 0); `CHK(q, 8'h03)
      xfer(1, 3, 5'h01, 8'h00);
      xfer(0, 7, 5'h03, 0); `CHK(q, 8'h02)
      pulse(14, 5);
      xfer(1, 6, 5'h12, 8'h00);
      xfer(0, 2, 5'h17, 0); `CHK(q, 8'h05)
      xfer(0, 2, 5'h16, 0); `CHK(q, 8'h00)
      xfer(0, 6, 5'h12, 0); `CHK(q, 8'h00)
      done("counts");
      pulse(26, 2);
      pulse(18, 1);
      xfer(0, 2, 5'h13, 0); `CHK(q, 8'h01)
      xfer(0, 2, 5'h14, 0); `CHK(q, 8'h00)
      xfer(0, 2, 5'h15, 0); `CHK(q, 8'h02)
      // long bursts on port 0 drive both header error counts into saturation
      pulse(16, 300);
      pulse(24, 4100);
      xfer(0, 0, 5'h13, 0); `CHK(q, octal_map_pkg::COR_MAX)
      xfer(0, 0, 5'h14, 0); `CHK(q, 8'h0F)
      xfer(0, 0, 5'h15, 0); `CHK(q, 8'hFF)
      done("header errors");
      report_and_stop();
   end
endmodule
`default_nettype wire
